/* File: rtl/irq_flag_pkg.sv */
// Constants, field layouts and types for the interrupt enable/flag block.
// Assumes an AHB-Lite master with 32-bit data and one register per word.
package irq_flag_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] CORE_CTL_IDX_BANK0 = 8'h0b;
   localparam logic [7:0] CORE_CTL_IDX_BANK1 = 8'h8b;
   localparam logic [7:0] PERIPH_EN_IDX      = 8'h8c;
   localparam logic [7:0] UNMAPPED_IDX       = 8'h00;

   // Byte address slicing of haddr
   localparam int IDX_LSB  = 2;
   localparam int IDX_MSB  = 9;
   localparam int ADDR_MSB = 31;

   // Reset values
   localparam logic [7:0] CORE_CTL_RESET  = 8'h00;
   localparam logic [7:0] PERIPH_EN_RESET = 8'h00;

   // Only the upper four enables live in this block
   localparam logic [7:0] PERIPH_EN_MASK = 8'hf0;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // Edges before the pin detectors may report anything
   localparam int SYNC_PRIME_STAGES = 3;

   // Core control register, bit 7 down to bit 0
   typedef struct packed {
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic timer_zero_overflow_enable;
      logic external_pin_irq_enable;
      logic port_change_irq_enable;
      logic timer_zero_overflow_flag;
      logic external_pin_irq_flag;
      logic port_change_irq_flag;
   } core_ctl_s;

   // First peripheral enable register, bit 7 down to bit 0
   typedef struct packed {
      logic       parallel_port_irq_enable;
      logic       converter_done_irq_enable;
      logic       serial_receive_irq_enable;
      logic       serial_transmit_irq_enable;
      logic [3:0] reserved;
   } periph_en_s;

   // Flag conditions supplied by the peripheral modules
   typedef struct packed {
      logic parallel_port_flag;
      logic converter_done_flag;
      logic serial_receive_flag;
      logic serial_transmit_flag;
   } periph_flags_s;

   // Data phase of the register bus
   typedef enum logic [1:0] {
      dp_none,
      dp_write,
      dp_read_wait,
      dp_read_data
   } bus_phase_e;

endpackage

/* File: rtl/pin_event_detect.sv */
// Pin synchroniser with rising-edge and change detection.
// Assumes pins are asynchronous to hclk; outputs are one-cycle pulses.
module pin_event_detect #(
   parameter int WIDTH = 1
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_rise,
   output logic      [WIDTH-1:0] pin_change
);

   logic [WIDTH-1:0] sync1_q;
   logic [WIDTH-1:0] sync2_q;
   logic [WIDTH-1:0] prev_q;
   logic [irq_flag_pkg::SYNC_PRIME_STAGES-1:0] prime_q;

   // Two-stage synchroniser; only sync2_q reads sync1_q
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pin_async;
         sync2_q <= sync1_q;
      end
   end

   // History stage, compared against the synchronised level
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prev_q <= '0;
      else
         prev_q <= sync2_q;
   end

   // Suppress a false event while the history still holds reset zeros
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prime_q <= '0;
      else
         prime_q <= {prime_q[irq_flag_pkg::SYNC_PRIME_STAGES-2:0], 1'b1};
   end

   // Event pulses
   assign pin_rise   = sync2_q & ~prev_q
                       & {WIDTH{prime_q[irq_flag_pkg::SYNC_PRIME_STAGES-1]}};
   assign pin_change = (sync2_q ^ prev_q)
                       & {WIDTH{prime_q[irq_flag_pkg::SYNC_PRIME_STAGES-1]}};

endmodule

/* File: rtl/irq_enable_flag.sv */
// Interrupt enable and flag logic with an AHB-Lite register slave.
// Assumes hclk-synchronous timer and peripheral flag inputs; the
// external and port pins arrive asynchronously and are synchronised.
//
// Functional notes
// RL1 - Global enable low blocks every request; high passes unmasked ones.
// RL2 - Peripheral enable low blocks all peripheral sources.
// RL3 - Bit 5 of core control enables the timer overflow request.
// RL4 - Timer overflow sets bit 2; it holds until software writes zero.
// RL5 - External pin event sets bit 1; held until software clears it.
// RL6 - Any change on four upper port pins sets bit 0 until cleared.
// RL7 - No peripheral request without core control bit 6 set.
// RL8 - Peripheral enable bit 6 unmasks converter completion.
// RL9 - Peripheral enable bit 5 unmasks serial receive full.
// RL10 - Peripheral enable bit 4 unmasks serial transmit empty.
// RL11 - Core control answers at two indices, one per bank, same storage.
// RL12 - Flags set regardless of individual or global enables.
// RL13 - Request is global AND (core pairs OR peripheral-enabled pairs).
// RL14 - Bit 4 gates pin flag, bit 3 port flag, enable bit 7 parallel.
//
// The AHB-Lite register port was chosen for this implementation.
module irq_enable_flag (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic                        hready,
   input  wire logic [31:0]                 hwdata,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   input  wire logic                        timer_zero_overflow,
   input  wire logic                        external_interrupt_pin,
   input  wire logic [3:0]                  upper_port_pins,
   input  wire irq_flag_pkg::periph_flags_s periph_flags,
   output logic                             core_irq_request
);

   irq_flag_pkg::bus_phase_e phase_q;
   irq_flag_pkg::bus_phase_e phase_d;
   irq_flag_pkg::core_ctl_s  ctl_q;
   irq_flag_pkg::core_ctl_s  ctl_d;
   irq_flag_pkg::periph_en_s pie_q;
   logic [7:0]               idx_q;
   logic [31:0]              hrdata_q;
   logic                     irq_q;
   logic                     irq_d;
   logic                     addr_ok;
   logic                     wr_ctl;
   logic                     wr_pie;
   logic [0:0]               ext_rise;
   logic [3:0]               port_change;
   logic                     core_pairs;
   logic                     periph_pairs;

   // Either bank index selects the same core control storage
   function automatic logic is_core_ctl(input logic [7:0] idx);
      is_core_ctl = (idx == irq_flag_pkg::CORE_CTL_IDX_BANK0)
                    || (idx == irq_flag_pkg::CORE_CTL_IDX_BANK1);
   endfunction

   // Read value of one register index; unmapped reads as zero
   function automatic logic [7:0] read_value(
      input logic [7:0]               idx,
      input irq_flag_pkg::core_ctl_s  ctl,
      input irq_flag_pkg::periph_en_s pie
   );
      if (is_core_ctl(idx))
         read_value = ctl;
      else if (idx == irq_flag_pkg::PERIPH_EN_IDX)
         read_value = pie & irq_flag_pkg::PERIPH_EN_MASK;
      else
         read_value = 8'h00;
   endfunction

   // Pin synchronisers; edge select lives elsewhere, rising edge here
   pin_event_detect #(
      .WIDTH (1)
   ) u_ext_pin (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .pin_async  (external_interrupt_pin),
      .pin_rise   (ext_rise),
      .pin_change ()
   );

   pin_event_detect #(
      .WIDTH (4)
   ) u_port_pins (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .pin_async  (upper_port_pins),
      .pin_rise   (),
      .pin_change (port_change)
   );

   // Address phase accepted when the bus is ready
   assign addr_ok = hsel && hready && htrans[1];

   // Bus phase sequencing; reads take one wait state so a write just
   // before sees its result
   always_comb
   begin
      phase_d = irq_flag_pkg::dp_none;
      case (phase_q)
         irq_flag_pkg::dp_read_wait:
            phase_d = irq_flag_pkg::dp_read_data;
         irq_flag_pkg::dp_none,
         irq_flag_pkg::dp_write,
         irq_flag_pkg::dp_read_data:
         begin
            if (addr_ok && hwrite)
               phase_d = irq_flag_pkg::dp_write;
            else if (addr_ok)
               phase_d = irq_flag_pkg::dp_read_wait;
            else
               phase_d = irq_flag_pkg::dp_none;
         end
         default:
            phase_d = irq_flag_pkg::dp_none;
      endcase
   end

   // Bus phase register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         phase_q <= irq_flag_pkg::dp_none;
      else
         phase_q <= phase_d;
   end

   // Address capture; anything above the decoded window is unmapped
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         idx_q <= irq_flag_pkg::UNMAPPED_IDX;
      else if (addr_ok)
      begin
         if (haddr[irq_flag_pkg::ADDR_MSB:irq_flag_pkg::IDX_MSB+1] != '0)
            idx_q <= irq_flag_pkg::UNMAPPED_IDX;
         else
            idx_q <= haddr[irq_flag_pkg::IDX_MSB:irq_flag_pkg::IDX_LSB];
      end
   end

   // Write strobes in the data phase
   assign wr_ctl = (phase_q == irq_flag_pkg::dp_write)
                   && is_core_ctl(idx_q);                        // [RL11]
   assign wr_pie = (phase_q == irq_flag_pkg::dp_write)
                   && (idx_q == irq_flag_pkg::PERIPH_EN_IDX);

   // Read data latched in the wait state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h0000_0000;
      else if (phase_q == irq_flag_pkg::dp_read_wait)
         hrdata_q <= {24'h00_0000, read_value(idx_q, ctl_q, pie_q)}; // [RL11]
   end

   // Bus outputs; response is always OKAY
   assign hrdata    = hrdata_q;
   assign hreadyout = (phase_q != irq_flag_pkg::dp_read_wait);
   assign hresp     = irq_flag_pkg::HRESP_OKAY;

   // Next core control value; a hardware set wins over a software clear
   always_comb
   begin
      ctl_d = ctl_q;
      if (wr_ctl)
         ctl_d = irq_flag_pkg::core_ctl_s'(hwdata[7:0]);         // [RL3]
      // Flags ignore every enable bit
      ctl_d.timer_zero_overflow_flag = ctl_d.timer_zero_overflow_flag
                                       | timer_zero_overflow;   // [RL4] [RL12]
      ctl_d.external_pin_irq_flag = ctl_d.external_pin_irq_flag
                                    | ext_rise[0];              // [RL5] [RL12]
      ctl_d.port_change_irq_flag = ctl_d.port_change_irq_flag
                                   | (|port_change);            // [RL6] [RL12]
   end

   // Core control register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctl_q <= irq_flag_pkg::CORE_CTL_RESET;
      else
         ctl_q <= ctl_d;
   end

   // Peripheral enable register; low nibble belongs to other logic
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pie_q <= irq_flag_pkg::PERIPH_EN_RESET;
      else if (wr_pie)
         pie_q <= hwdata[7:0] & irq_flag_pkg::PERIPH_EN_MASK; // [RL8] [RL9] [RL10]
   end

   // Flag-and-enable pairs
   assign core_pairs =
      (ctl_q.timer_zero_overflow_enable
       && ctl_q.timer_zero_overflow_flag)                        // [RL3]
      || (ctl_q.external_pin_irq_enable
          && ctl_q.external_pin_irq_flag)                        // [RL14]
      || (ctl_q.port_change_irq_enable
          && ctl_q.port_change_irq_flag);                        // [RL14]
   assign periph_pairs =
      (pie_q.parallel_port_irq_enable
       && periph_flags.parallel_port_flag)                       // [RL14]
      || (pie_q.converter_done_irq_enable
          && periph_flags.converter_done_flag)                   // [RL8]
      || (pie_q.serial_receive_irq_enable
          && periph_flags.serial_receive_flag)                   // [RL9]
      || (pie_q.serial_transmit_irq_enable
          && periph_flags.serial_transmit_flag);                 // [RL10]

   // Request toward the core, registered to keep it glitch free
   assign irq_d = ctl_q.global_irq_enable                        // [RL1]
                  && (core_pairs
                      || (ctl_q.peripheral_irq_enable            // [RL2] [RL7]
                          && periph_pairs));                     // [RL13]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_q <= 1'b0;
      else
         irq_q <= irq_d;
   end

   assign core_irq_request = irq_q;

   // Checks, all on hclk
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_global_blocks_all: // [RL1]
   assert property (!ctl_q.global_irq_enable |=> !core_irq_request)
      else $error("request while global enable low");

   a_periph_needs_enable: // [RL2] [RL7]
   assert property ((!ctl_q.peripheral_irq_enable && !core_pairs)
                    |=> !core_irq_request)
      else $error("peripheral request without peripheral enable");

   a_timer_flag_set_wins: // [RL4] [RL12]
   assert property ((timer_zero_overflow && wr_ctl && !hwdata[2])
                    |=> ctl_q.timer_zero_overflow_flag)
      else $error("timer flag lost against a clear");

   a_timer_flag_holds: // [RL4]
   assert property ((ctl_q.timer_zero_overflow_flag && !wr_ctl)
                    |=> ctl_q.timer_zero_overflow_flag)
      else $error("timer flag dropped without a write");

   a_ext_flag_set: // [RL5] [RL12]
   assert property (ext_rise[0] |=> ctl_q.external_pin_irq_flag)
      else $error("external pin flag not set");

   a_port_flag_set: // [RL6]
   assert property ((|port_change) |=> ctl_q.port_change_irq_flag)
      else $error("port change flag not set");

   a_core_pair_request: // [RL13] [RL14]
   assert property ((ctl_q.global_irq_enable
                     && ctl_q.external_pin_irq_enable
                     && ctl_q.external_pin_irq_flag)
                    |=> core_irq_request)
      else $error("enabled pin flag gave no request");

   a_converter_request: // [RL8] [RL2]
   assert property ((ctl_q.global_irq_enable
                     && ctl_q.peripheral_irq_enable
                     && pie_q.converter_done_irq_enable
                     && periph_flags.converter_done_flag)
                    |=> core_irq_request)
      else $error("enabled converter flag gave no request");

   a_enable_write: // [RL3] [RL11]
   assert property (wr_ctl |=> ctl_q.timer_zero_overflow_enable
                                == $past(hwdata[5]))
      else $error("core control write lost");

   a_pie_write: // [RL9] [RL10]
   assert property (wr_pie |=> (pie_q.serial_receive_irq_enable
                                == $past(hwdata[5]))
                               && (pie_q.serial_transmit_irq_enable
                                   == $past(hwdata[4])))
      else $error("peripheral enable write lost");

   a_mirror_read: // [RL11]
   assert property ((phase_q == irq_flag_pkg::dp_read_data)
                    && is_core_ctl(idx_q)
                    |-> hrdata[7:0] == $past(ctl_q))
      else $error("core control read mismatch");

   a_read_wait_one: // [RL11]
   assert property ((addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state not exactly one cycle");

   c_bank1_write: cover property (wr_ctl
      && idx_q == irq_flag_pkg::CORE_CTL_IDX_BANK1);
   c_word_read: cover property (addr_ok && !hwrite
      && hsize == irq_flag_pkg::HSIZE_WORD);
   c_request_rise: cover property (!core_irq_request ##1 core_irq_request);
   c_set_over_clear: cover property (timer_zero_overflow && wr_ctl
      && !hwdata[2]);

endmodule

/* File: test/cpu_irq_entry.sv */
// Model of the CPU core's interrupt entry: counts cycles of request.
// Assumes the request is a level synchronous to hclk.
module cpu_irq_entry (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        core_irq_request,
   output logic      [15:0] req_cycles
);
   timeunit 1ns;
   timeprecision 1ps;

   // Cycles in which the core would take an entry; vectoring not modelled
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req_cycles <= 16'h0000;
      else if (core_irq_request)
         req_cycles <= req_cycles + 16'h0001;
   end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the interrupt enable and flag block.
// Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = irq_flag_pkg::HSIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        tmr_ovf = 1'b0;
   logic        ext_pin = 1'b0;
   logic [3:0]  port_pins = 4'h0;
   logic [3:0]  pflags = 4'h0;
   logic        core_irq_request;
   logic [15:0] req_cycles;
   logic [31:0] rd;
   logic [7:0]  ctl;
   logic [7:0]  pie;
   logic [19:0] corner [11];
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          hits = 0;
   int          seed = 32'h58a486de;

   localparam logic [7:0] B0 = irq_flag_pkg::CORE_CTL_IDX_BANK0;
   localparam logic [7:0] B1 = irq_flag_pkg::CORE_CTL_IDX_BANK1;
   localparam logic [7:0] PE = irq_flag_pkg::PERIPH_EN_IDX;

   irq_enable_flag dut_u (
      .hclk                   (hclk),
      .hresetn                (hresetn),
      .hsel                   (hsel),
      .haddr                  (haddr),
      .htrans                 (htrans),
      .hwrite                 (hwrite),
      .hsize                  (hsize),
      .hready                 (hreadyout),
      .hwdata                 (hwdata),
      .hrdata                 (hrdata),
      .hreadyout              (hreadyout),
      .hresp                  (hresp),
      .timer_zero_overflow    (tmr_ovf),
      .external_interrupt_pin (ext_pin),
      .upper_port_pins        (port_pins),
      .periph_flags           (pflags),
      .core_irq_request       (core_irq_request)
   );

   cpu_irq_entry cpu_u (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .core_irq_request (core_irq_request),
      .req_cycles       (req_cycles)
   );

   // Clock and hang guard
   always #5 hclk = ~hclk;

   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One single transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {22'h00_0000, idx, 2'b00};
      htrans <= irq_flag_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      check("hresp", hresp, irq_flag_pkg::HRESP_OKAY);
   endtask

   // Expected request from register bytes and peripheral flags
   function automatic logic exp_req(input logic [7:0] c,
                                    input logic [7:0] p,
                                    input logic [3:0] f);
      return c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) |
                     (c[6] & (|(p[7:4] & f))));
   endfunction

   task automatic expect_ctl(input string what, input logic [7:0] v);
      bus(1'b0, B0, 8'h00, rd);
      check(what, rd, {24'h00_0000, v});
   endtask

   initial
   begin
      // Corner cases: {core control, peripheral enable, peripheral flags}
      corner = '{20'h7f_f0f, 20'hc0_808, 20'h80_f0f, 20'hc0_404,
                 20'hc0_202, 20'hc0_101, 20'hc0_708, 20'hb4_000,
                 20'h92_000, 20'h89_000, 20'ha2_000};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      check("req reset", core_irq_request, 1'b0);
      expect_ctl("ctl reset", irq_flag_pkg::CORE_CTL_RESET);
      bus(1'b0, PE, 8'h00, rd);
      check("pie reset", rd, {24'h00_0000, irq_flag_pkg::PERIPH_EN_RESET});
      // Both banks reach one register; lower enable bits are not kept
      for (int i = 0; i < 8; i++)
      begin
         ctl = 8'($random(seed));
         bus(1'b1, i[0] ? B1 : B0, ctl, rd);
         bus(1'b0, i[0] ? B0 : B1, 8'h00, rd);
         check("ctl alias", rd, {24'h00_0000, ctl});
         pie = 8'($random(seed));
         bus(1'b1, PE, pie, rd);
         bus(1'b0, PE, 8'h00, rd);
         check("pie", rd, {24'h00_0000, pie & 8'hf0});
      end
      bus(1'b1, irq_flag_pkg::UNMAPPED_IDX, 8'hff, rd);
      bus(1'b0, irq_flag_pkg::UNMAPPED_IDX, 8'h00, rd);
      check("unmapped", rd, 32'h0000_0000);
      bus(1'b1, B0, 8'h00, rd);
      // Flags set with every core control enable off, and stay until written zero
      tmr_ovf <= 1'b1;
      @(posedge hclk);
      tmr_ovf <= 1'b0;
      repeat (5) @(posedge hclk);
      expect_ctl("timer flag", 8'h04);
      check("req gated", core_irq_request, 1'b0);
      bus(1'b1, B1, 8'h00, rd);
      expect_ctl("timer clear", 8'h00);
      ext_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      expect_ctl("pin flag", 8'h02);
      ext_pin <= 1'b0;
      repeat (8) @(posedge hclk);
      bus(1'b1, B0, 8'h00, rd);
      expect_ctl("pin clear", 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         port_pins <= port_pins ^ (4'h1 << i);
         repeat (8) @(posedge hclk);
         expect_ctl("port flag", 8'h01);
         bus(1'b1, B0, 8'h00, rd);
      end
      // Request from every pairing: corners first, then random mixes
      for (int i = 0; i < 150; i++)
      begin
         if (i < 11)
            {ctl, pie, pflags} <= corner[i];
         else
            {ctl, pie, pflags} <= 20'($random(seed));
         @(posedge hclk);
         bus(1'b1, B1, ctl, rd);
         bus(1'b1, PE, pie, rd);
         repeat (2) @(posedge hclk);
         if (exp_req(ctl, pie, pflags))
            hits++;
         check("request", core_irq_request, exp_req(ctl, pie, pflags));
      end
      check("core saw", req_cycles != 16'h0000, hits != 0);
      end_of_test();
   end
endmodule
